// ==== clk_tune_pkg.sv ====
package clk_tune_pkg;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TUNE_OFS = 8'h04;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [7:0] KEY_HI_FIRST = 8'h78;
  localparam logic [7:0] KEY_HI_SECOND = 8'h9a;
  localparam logic [7:0] KEY_LO_FIRST = 8'h46;
  localparam logic [7:0] KEY_LO_SECOND = 8'h57;
  localparam int SRC_W = 3;
  localparam int TRIM_W = 6;
  localparam int CTRL_REQ_BIT = 0;
  localparam int CTRL_LOCK_BIT = 5;
  localparam int CTRL_NSRC_LSB = 8;
  localparam int CTRL_CSRC_LSB = 12;
  localparam int TUNE_EN_BIT = 15;
  localparam int TUNE_SRC_BIT = 12;
  localparam int TUNE_DRIFT_BIT = 11;
  localparam int TUNE_LPOL_BIT = 10;
  localparam int TUNE_RANGE_BIT = 9;
  localparam int TUNE_RPOL_BIT = 8;
  localparam logic [2:0] SRC_RESET = 3'h0;
  localparam logic [5:0] TRIM_RESET = 6'h00;
  localparam logic [5:0] TRIM_MAX = 6'h1f;
  localparam logic [5:0] TRIM_MIN = 6'h20;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SETTLE_NS = 2000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MEAS_W = 16;
  localparam int RC_NOMINAL_HZ = 8000000;
  localparam int SOF_PERIOD_US = 1000;
  localparam int SECONDARY_CRYSTAL_OSC_HZ = 32768;
  localparam int SECONDARY_CRYSTAL_OSC_WINDOW = 32;
  localparam int DRIFT_PPT = 2;
  localparam int RANGE_PPT = 15;
  localparam int SOF_EXPECT = RC_NOMINAL_HZ / 1000 * SOF_PERIOD_US / 1000;
  localparam int SECONDARY_CRYSTAL_OSC_EXPECT = (RC_NOMINAL_HZ * SECONDARY_CRYSTAL_OSC_WINDOW + SECONDARY_CRYSTAL_OSC_HZ / 2) / SECONDARY_CRYSTAL_OSC_HZ;
  localparam logic [16:0] SOF_DRIFT_THR = 17'(SOF_EXPECT * DRIFT_PPT / 1000);
  localparam logic [16:0] SOF_RANGE_THR = 17'(SOF_EXPECT * RANGE_PPT / 1000);
  localparam logic [16:0] SECONDARY_CRYSTAL_OSC_DRIFT_THR = 17'(SECONDARY_CRYSTAL_OSC_EXPECT * DRIFT_PPT / 1000);
  localparam logic [16:0] SECONDARY_CRYSTAL_OSC_RANGE_THR = 17'(SECONDARY_CRYSTAL_OSC_EXPECT * RANGE_PPT / 1000);
  typedef enum logic [2:0] {KEY_IDLE = 3'b001, KEY_GOT_FIRST = 3'b010, KEY_OPEN = 3'b100} key_state_e;
  typedef enum logic [1:0] {SW_IDLE = 2'b01, SW_WAIT = 2'b10} switch_state_e;
endpackage

// ==== osc_key_seq.sv ====
`timescale 1ns/10ps
`default_nettype none
module osc_key_seq #(
  parameter logic [7:0] KEY_FIRST = 8'h00,
  parameter logic [7:0] KEY_SECOND = 8'h00
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic wr_any,
  input wire logic lane_wr,
  input wire logic [7:0] wr_byte,
  output logic slot_open
);
  clk_tune_pkg::key_state_e state_reg, state_next;
  wire first_hit = lane_wr && (wr_byte == KEY_FIRST);
  wire second_hit = lane_wr && (wr_byte == KEY_SECOND);

  // Any other bus write in between breaks the pair; repeating the first key keeps it armed
  always_comb begin
    state_next = state_reg;
    if (wr_any) begin
      case (state_reg)
        clk_tune_pkg::KEY_IDLE: state_next = first_hit ? clk_tune_pkg::KEY_GOT_FIRST : clk_tune_pkg::KEY_IDLE;
        clk_tune_pkg::KEY_GOT_FIRST: state_next = second_hit ? clk_tune_pkg::KEY_OPEN :
          (first_hit ? clk_tune_pkg::KEY_GOT_FIRST : clk_tune_pkg::KEY_IDLE);
        clk_tune_pkg::KEY_OPEN: state_next = clk_tune_pkg::KEY_IDLE;
        default: state_next = clk_tune_pkg::KEY_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) state_reg <= clk_tune_pkg::KEY_IDLE;
    else state_reg <= state_next;
  end

  assign slot_open = (state_reg == clk_tune_pkg::KEY_OPEN);

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_key_open;
    (state_reg == clk_tune_pkg::KEY_GOT_FIRST && wr_any && second_hit) |=> slot_open;
  endproperty
  a_key_open: assert property (p_key_open) else $error("unlock pair did not open slot");
  property p_key_once;
    (slot_open && wr_any) |=> !slot_open;
  endproperty
  a_key_once: assert property (p_key_once) else $error("slot stayed open after a write");
  property p_key_cause;
    $rose(slot_open) |-> $past(state_reg == clk_tune_pkg::KEY_GOT_FIRST && second_hit);
  endproperty
  a_key_cause: assert property (p_key_cause) else $error("slot opened without key pair");
endmodule
`default_nettype wire

// ==== ref_freq_meter.sv ====
`timescale 1ns/10ps
`default_nettype none
module ref_freq_meter #(
  parameter int CNT_W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic ref_tick,
  input wire logic rc_tick,
  output logic [CNT_W-1:0] meas_count,
  output logic meas_valid
);
  logic [CNT_W-1:0] acc_reg;
  logic started_reg;
  wire acc_full = &acc_reg;

  // Counts RC ticks between two reference marks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_reg <= '0;
      started_reg <= 1'b0;
      meas_count <= '0;
      meas_valid <= 1'b0;
    end else begin
      meas_valid <= 1'b0;
      if (!run) begin
        acc_reg <= '0;
        started_reg <= 1'b0;
      end else if (ref_tick) begin
        if (started_reg) begin
          meas_count <= acc_reg;
          meas_valid <= 1'b1;
        end
        started_reg <= 1'b1;
        acc_reg <= {{(CNT_W-1){1'b0}}, rc_tick};
      end else if (rc_tick && !acc_full) begin
        acc_reg <= acc_reg + CNT_W'(1);
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_meas_cause;
    meas_valid |-> $past(run && ref_tick && started_reg);
  endproperty
  a_meas_cause: assert property (p_meas_cause) else $error("measurement without reference mark");
  property p_meas_idle;
    !run |=> !meas_valid;
  endproperty
  a_meas_idle: assert property (p_meas_idle) else $error("measurement while stopped");
endmodule
`default_nettype wire

// ==== clock_switch_rc_self_tune.sv ====
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module clock_switch_rc_self_tune #(
  parameter int SETTLE_CYCLES = clk_tune_pkg::SETTLE_CYC,
  parameter int SECONDARY_CRYSTAL_OSC_WINDOW = clk_tune_pkg::SECONDARY_CRYSTAL_OSC_WINDOW
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] src_ready,
  input wire logic pll_locked,
  input wire logic sof_pulse,
  input wire logic secondary_crystal_osc_tick,
  input wire logic secondary_crystal_osc_enabled,
  input wire logic rc_tick,
  output logic [2:0] clk_sel,
  output logic [5:0] rc_trim,
  output logic selftune_irq_flag
);
  localparam int MW = clk_tune_pkg::MEAS_W;

  // Bus slave state
  logic dp_wr_reg;
  logic [7:0] dp_addr_reg;
  logic [2:0] dp_size_reg;
  logic rd_pend_reg;
  logic hreadyout_reg;
  logic hresp_reg;
  logic [31:0] hrdata_reg;

  // Register fields
  logic [2:0] new_src_reg;
  logic [2:0] cur_src_reg;
  logic req_reg;
  logic lock_reg;
  logic en_reg;
  logic src_reg;
  logic lpol_reg;
  logic rpol_reg;
  logic drift_reg;
  logic range_reg;
  logic [5:0] trim_reg;
  logic irq_reg;

  // Switch sequencer and crystal window counter
  clk_tune_pkg::switch_state_e sw_state_reg;
  logic [15:0] settle_cnt_reg;
  logic [7:0] win_cnt_reg;

  // Address phase decode
  logic addr_ok;
  assign addr_ok = hsel && hready && htrans[1];

  // Data phase decode and byte lanes
  logic wr_fire, is_ctrl, is_tune, size_word, size_half, size_byte;
  logic lane_lo, lane_hi;
  logic wr_ctrl_lo, wr_ctrl_hi, wr_tune_lo, wr_tune_hi;
  assign wr_fire = dp_wr_reg;
  assign is_ctrl = (dp_addr_reg[7:2] == clk_tune_pkg::CTRL_OFS[7:2]);
  assign is_tune = (dp_addr_reg[7:2] == clk_tune_pkg::TUNE_OFS[7:2]);
  assign size_word = (dp_size_reg == clk_tune_pkg::HSIZE_WORD);
  assign size_half = (dp_size_reg == clk_tune_pkg::HSIZE_HALF) && !dp_addr_reg[1];
  assign size_byte = (dp_size_reg == clk_tune_pkg::HSIZE_BYTE) && !dp_addr_reg[1];
  assign lane_lo = size_word || size_half || (size_byte && !dp_addr_reg[0]);
  assign lane_hi = size_word || size_half || (size_byte && dp_addr_reg[0]);
  assign wr_ctrl_lo = wr_fire && is_ctrl && lane_lo;
  assign wr_ctrl_hi = wr_fire && is_ctrl && lane_hi;
  assign wr_tune_lo = wr_fire && is_tune && lane_lo;
  assign wr_tune_hi = wr_fire && is_tune && lane_hi;

  // Write data fields
  logic [2:0] nsrc_wdata;
  logic [5:0] trim_wdata;
  assign nsrc_wdata = hwdata[clk_tune_pkg::CTRL_NSRC_LSB +: clk_tune_pkg::SRC_W];
  assign trim_wdata = hwdata[clk_tune_pkg::TRIM_W-1:0];

  // Unlock sequencers for each protected byte
  logic hi_open, lo_open;
  osc_key_seq #(.KEY_FIRST(clk_tune_pkg::KEY_HI_FIRST), .KEY_SECOND(clk_tune_pkg::KEY_HI_SECOND)) u_key_hi (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_any(wr_fire),
    .lane_wr(wr_ctrl_hi),
    .wr_byte(hwdata[15:8]),
    .slot_open(hi_open)
  );
  osc_key_seq #(.KEY_FIRST(clk_tune_pkg::KEY_LO_FIRST), .KEY_SECOND(clk_tune_pkg::KEY_LO_SECOND)) u_key_lo (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_any(wr_fire),
    .lane_wr(wr_ctrl_lo),
    .wr_byte(hwdata[7:0]),
    .slot_open(lo_open)
  );

  logic accept_hi, start_sw;
  assign accept_hi = wr_ctrl_hi && hi_open;
  assign start_sw = wr_ctrl_lo && lo_open && hwdata[clk_tune_pkg::CTRL_REQ_BIT];

  // Switch completion
  logic sw_wait, sw_end, sw_ok, sw_clear;
  assign sw_wait = (sw_state_reg == clk_tune_pkg::SW_WAIT);
  assign sw_end = sw_wait && (settle_cnt_reg == 16'h0000);
  assign sw_ok = sw_end && src_ready[new_src_reg];
  assign sw_clear = sw_ok && !start_sw;

  // Read words
  logic [31:0] ctrl_word, tune_word, rd_word;
  assign ctrl_word = {16'h0000, 1'b0, cur_src_reg, 1'b0, new_src_reg, 2'b00, lock_reg, 4'h0, req_reg};
  assign tune_word = {16'h0000, en_reg, 2'b00, src_reg, drift_reg, lpol_reg, range_reg, rpol_reg, 2'b00, trim_reg};
  assign rd_word = is_ctrl ? ctrl_word : (is_tune ? tune_word : 32'h0000_0000);

  // Reference selection and measurement
  logic run, win_tick, ref_tick, meas_valid;
  logic [MW-1:0] meas_count;
  assign run = en_reg && (src_reg || secondary_crystal_osc_enabled);
  assign win_tick = secondary_crystal_osc_tick && (win_cnt_reg == 8'(SECONDARY_CRYSTAL_OSC_WINDOW - 1));
  assign ref_tick = run && (src_reg ? sof_pulse : win_tick);

  ref_freq_meter #(.CNT_W(MW)) u_meter (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(run),
    .ref_tick(ref_tick),
    .rc_tick(rc_tick),
    .meas_count(meas_count),
    .meas_valid(meas_valid)
  );

  // Deviation from the nominal count for the chosen reference
  logic [16:0] expect_cnt, diff, dev_mag, drift_thr, range_thr;
  logic too_fast, too_slow, loop_step;
  assign expect_cnt = src_reg ? 17'(clk_tune_pkg::SOF_EXPECT) : 17'(clk_tune_pkg::SECONDARY_CRYSTAL_OSC_EXPECT);
  assign drift_thr = src_reg ? clk_tune_pkg::SOF_DRIFT_THR : clk_tune_pkg::SECONDARY_CRYSTAL_OSC_DRIFT_THR;
  assign range_thr = src_reg ? clk_tune_pkg::SOF_RANGE_THR : clk_tune_pkg::SECONDARY_CRYSTAL_OSC_RANGE_THR;
  assign diff = {1'b0, meas_count} - expect_cnt;
  assign dev_mag = diff[16] ? 17'(-diff) : diff;
  assign too_fast = !diff[16] && (dev_mag > {1'b0, drift_thr[16:1]});
  assign too_slow = diff[16] && (dev_mag > {1'b0, drift_thr[16:1]});
  assign loop_step = meas_valid && en_reg;

  logic irq_next;
  assign irq_next = en_reg && ((drift_reg ^ lpol_reg) || (range_reg ^ rpol_reg));

  // Bus slave: writes take no wait, reads one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
      dp_size_reg <= 3'h0;
      rd_pend_reg <= 1'b0;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      dp_wr_reg <= addr_ok && hwrite;
      rd_pend_reg <= addr_ok && !hwrite;
      hreadyout_reg <= !(addr_ok && !hwrite);
      hresp_reg <= 1'b0;
      if (addr_ok) begin
        dp_addr_reg <= haddr[7:0];
        dp_size_reg <= hsize;
      end
      if (rd_pend_reg) hrdata_reg <= rd_word;
    end
  end

  // Oscillator control register and switch sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      new_src_reg <= clk_tune_pkg::SRC_RESET;
      cur_src_reg <= clk_tune_pkg::SRC_RESET;
      req_reg <= 1'b0;
      lock_reg <= 1'b0;
      sw_state_reg <= clk_tune_pkg::SW_IDLE;
      settle_cnt_reg <= 16'h0000;
    end else begin
      lock_reg <= pll_locked;
      if (accept_hi) new_src_reg <= nsrc_wdata;
      if (start_sw) req_reg <= 1'b1;
      else if (sw_clear) req_reg <= 1'b0;
      if (sw_clear) cur_src_reg <= new_src_reg;
      case (sw_state_reg)
        clk_tune_pkg::SW_IDLE: begin
          if (start_sw) begin
            sw_state_reg <= clk_tune_pkg::SW_WAIT;
            settle_cnt_reg <= 16'(SETTLE_CYCLES - 1);
          end
        end
        clk_tune_pkg::SW_WAIT: begin
          if (start_sw) settle_cnt_reg <= 16'(SETTLE_CYCLES - 1);
          else if (sw_end) sw_state_reg <= clk_tune_pkg::SW_IDLE;
          else settle_cnt_reg <= settle_cnt_reg - 16'h0001;
        end
        default: sw_state_reg <= clk_tune_pkg::SW_IDLE;
      endcase
    end
  end

  // Tuning register fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_reg <= 1'b0;
      src_reg <= 1'b0;
      lpol_reg <= 1'b0;
      rpol_reg <= 1'b0;
    end else if (wr_tune_hi) begin
      en_reg <= hwdata[clk_tune_pkg::TUNE_EN_BIT];
      src_reg <= hwdata[clk_tune_pkg::TUNE_SRC_BIT];
      lpol_reg <= hwdata[clk_tune_pkg::TUNE_LPOL_BIT];
      rpol_reg <= hwdata[clk_tune_pkg::TUNE_RPOL_BIT];
    end
  end

  // Trim loop and status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trim_reg <= clk_tune_pkg::TRIM_RESET;
      drift_reg <= 1'b0;
      range_reg <= 1'b0;
      irq_reg <= 1'b0;
      win_cnt_reg <= 8'h00;
    end else begin
      irq_reg <= irq_next;
      if (!run || src_reg) win_cnt_reg <= 8'h00;
      else if (win_tick) win_cnt_reg <= 8'h00;
      else if (secondary_crystal_osc_tick) win_cnt_reg <= win_cnt_reg + 8'h01;
      if (!en_reg) begin
        drift_reg <= 1'b0;
        range_reg <= 1'b0;
        if (wr_tune_lo) trim_reg <= trim_wdata;
      end else if (loop_step) begin
        drift_reg <= (dev_mag > drift_thr);
        range_reg <= (dev_mag > range_thr);
        if (too_slow && trim_reg != clk_tune_pkg::TRIM_MAX) trim_reg <= trim_reg + 6'h01;
        else if (too_fast && trim_reg != clk_tune_pkg::TRIM_MIN) trim_reg <= trim_reg - 6'h01;
      end
    end
  end

  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign hrdata = hrdata_reg;
  assign clk_sel = cur_src_reg;
  assign rc_trim = trim_reg;
  assign selftune_irq_flag = irq_reg;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_trim_frozen;
    (wr_tune_lo && en_reg && !loop_step) |=> $stable(trim_reg);
  endproperty
  a_trim_frozen: assert property (p_trim_frozen) else $error("trim changed by software while tuning");
  property p_trim_sw;
    (wr_tune_lo && !en_reg) |=> (trim_reg == $past(trim_wdata));
  endproperty
  a_trim_sw: assert property (p_trim_sw) else $error("trim write lost while idle");
  property p_switch_ok;
    sw_clear |=> (!req_reg && clk_sel == $past(new_src_reg));
  endproperty
  a_switch_ok: assert property (p_switch_ok) else $error("successful switch not reported");
  property p_switch_fail;
    (sw_end && !src_ready[new_src_reg]) |=> (req_reg && $stable(cur_src_reg));
  endproperty
  a_switch_fail: assert property (p_switch_fail) else $error("failed switch cleared request");
  property p_switch_start;
    start_sw |=> (req_reg && sw_wait);
  endproperty
  a_switch_start: assert property (p_switch_start) else $error("switch request not started");
  property p_req_guard;
    (wr_ctrl_lo && !lo_open && !sw_clear) |=> $stable(req_reg);
  endproperty
  a_req_guard: assert property (p_req_guard) else $error("request set without unlock");
  property p_nsrc_guard;
    (wr_ctrl_hi && !hi_open) |=> $stable(new_src_reg);
  endproperty
  a_nsrc_guard: assert property (p_nsrc_guard) else $error("new source written without unlock");
  property p_nsrc_take;
    (wr_ctrl_hi && hi_open) |=> (new_src_reg == $past(nsrc_wdata));
  endproperty
  a_nsrc_take: assert property (p_nsrc_take) else $error("unlocked source write lost");
  property p_irq_off;
    !en_reg |=> !selftune_irq_flag;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt while tuning disabled");
  property p_drift;
    (loop_step && dev_mag > drift_thr) |=> drift_reg ##1
      (selftune_irq_flag == $past(en_reg && (!lpol_reg || (range_reg ^ rpol_reg))));
  endproperty
  a_drift: assert property (p_drift) else $error("drift not flagged or not signalled");
  property p_range;
    (loop_step && dev_mag > range_thr) |=> (range_reg && drift_reg);
  endproperty
  a_range: assert property (p_range) else $error("range condition not flagged");
  property p_trim_up;
    (loop_step && too_slow && trim_reg != clk_tune_pkg::TRIM_MAX) |=> (trim_reg == 6'($past(trim_reg) + 6'h01));
  endproperty
  a_trim_up: assert property (p_trim_up) else $error("slow oscillator not trimmed up");
  property p_trim_down;
    (loop_step && too_fast && trim_reg != clk_tune_pkg::TRIM_MIN) |=> (trim_reg == 6'($past(trim_reg) - 6'h01));
  endproperty
  a_trim_down: assert property (p_trim_down) else $error("fast oscillator not trimmed down");
  property p_trim_hold;
    (loop_step && !too_fast && !too_slow) |=> $stable(trim_reg);
  endproperty
  a_trim_hold: assert property (p_trim_hold) else $error("trim moved inside the dead band");
  property p_flags_off;
    !en_reg |=> (!drift_reg && !range_reg);
  endproperty
  a_flags_off: assert property (p_flags_off) else $error("status flags set while tuning disabled");
  property p_sel_hold;
    !sw_clear |=> $stable(clk_sel);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("clock source changed without a switch");
  property p_rd_data;
    rd_pend_reg |=> (hrdata == $past(rd_word) && hreadyout && !hresp);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data not presented");
  property p_secondary_crystal_osc_gate;
    (!src_reg && !secondary_crystal_osc_enabled) |-> !ref_tick;
  endproperty
  a_secondary_crystal_osc_gate: assert property (p_secondary_crystal_osc_gate) else $error("tuning without crystal enabled");
  property p_read_wait;
    (addr_ok && !hwrite) |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

  c_switch_start: cover property (start_sw);
  c_switch_ok: cover property (sw_clear);
  c_switch_fail: cover property (sw_end && !src_ready[new_src_reg]);
  c_drift: cover property (loop_step && dev_mag > drift_thr);
  c_irq: cover property (en_reg && $rose(selftune_irq_flag));
endmodule
`default_nettype wire

// ==== ref_source_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module ref_source_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [15:0] sof_period,
  input wire logic [15:0] secondary_crystal_osc_period,
  output logic sof_pulse,
  output logic secondary_crystal_osc_tick,
  output logic rc_tick
);
  logic [15:0] sof_cnt;
  logic [15:0] secondary_crystal_osc_cnt;
  wire sof_end = sof_cnt == sof_period - 16'h0001;
  wire secondary_crystal_osc_end = secondary_crystal_osc_cnt == secondary_crystal_osc_period - 16'h0001;
  // RC runs at the bus rate so the measured count equals the cycles between reference marks (SOF period, or crystal period times the window)
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sof_cnt <= 16'h0000;
      secondary_crystal_osc_cnt <= 16'h0000;
      sof_pulse <= 1'b0;
      secondary_crystal_osc_tick <= 1'b0;
      rc_tick <= 1'b0;
    end else begin
      rc_tick <= 1'b1;
      sof_cnt <= sof_end ? 16'h0000 : sof_cnt + 16'h0001;
      sof_pulse <= sof_end;
      secondary_crystal_osc_cnt <= secondary_crystal_osc_end ? 16'h0000 : secondary_crystal_osc_cnt + 16'h0001;
      secondary_crystal_osc_tick <= secondary_crystal_osc_end;
    end
  end
endmodule
`default_nettype wire

// ==== clock_switch_rc_self_tune_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module clock_switch_rc_self_tune_tb;
  localparam int SET = 3;
  localparam logic [31:0] CA = 32'(clk_tune_pkg::CTRL_OFS);
  localparam logic [31:0] TA = 32'(clk_tune_pkg::TUNE_OFS);
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] src_ready = 8'hff;
  logic pll_locked = 1'b0;
  logic secondary_crystal_osc_enabled = 1'b0;
  logic [15:0] sof_period = 16'h1e78;
  logic [15:0] secondary_crystal_osc_period = 16'h076c;
  wire hready;
  wire hresp;
  wire [31:0] hrdata;
  wire sof_pulse;
  wire secondary_crystal_osc_tick;
  wire rc_tick;
  wire [2:0] clk_sel;
  wire [5:0] rc_trim;
  wire selftune_irq_flag;
  int mismatches = 0;
  int comparisons = 0;
  always #50 hclk = ~hclk;
  ref_source_model ref_src (.hclk(hclk), .hresetn(hresetn), .sof_period(sof_period),
    .secondary_crystal_osc_period(secondary_crystal_osc_period), .sof_pulse(sof_pulse), .secondary_crystal_osc_tick(secondary_crystal_osc_tick), .rc_tick(rc_tick));
  clock_switch_rc_self_tune #(.SETTLE_CYCLES(SET), .SECONDARY_CRYSTAL_OSC_WINDOW(4)) DUT (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .src_ready(src_ready),
    .pll_locked(pll_locked), .sof_pulse(sof_pulse), .secondary_crystal_osc_tick(secondary_crystal_osc_tick), .secondary_crystal_osc_enabled(secondary_crystal_osc_enabled),
    .rc_tick(rc_tick), .clk_sel(clk_sel), .rc_trim(rc_trim), .selftune_irq_flag(selftune_irq_flag));
  task automatic give_verdict();
    if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= clk_tune_pkg::HSIZE_WORD;
    htrans <= clk_tune_pkg::HTRANS_NONSEQ;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    chk(r, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic wait_trim(input logic [5:0] exp);
    int n;
    n = 0;
    while (rc_trim !== exp && n < 20000) begin
      @(posedge hclk);
      n++;
    end
    chk(rc_trim, exp);
    repeat (4) @(posedge hclk);
  endtask
  // Full unlock and switch sequence, no other writes in between
  task automatic sw(input logic [2:0] src);
    wr(CA, 32'h7800);
    wr(CA, 32'h9a00);
    wr(CA, {21'h0, src, 8'h00});
    wr(CA, 32'h0046);
    wr(CA, 32'h0057);
    wr(CA, 32'h0001);
  endtask
  task automatic t_reset();
    chk({clk_sel, rc_trim, selftune_irq_flag}, 32'h0);
    rd(CA, 32'h0);
    rd(TA, 32'h0);
    rd(32'h8, 32'h0);
  endtask
  task automatic t_switch_ok();
    sw(3'h3);
    chk(clk_sel, 32'h0);
    repeat (SET + 3) @(posedge hclk);
    chk(clk_sel, 32'h3);
    rd(CA, 32'h3300);
  endtask
  task automatic t_broken();
    wr(CA, 32'h7800);
    wr(TA, 32'h0);
    wr(CA, 32'h9a00);
    wr(CA, 32'h0600);
    wr(CA, 32'h0046);
    wr(TA, 32'h0);
    wr(CA, 32'h0057);
    wr(CA, 32'h0001);
    repeat (SET + 3) @(posedge hclk);
    rd(CA, 32'h3300);
  endtask
  task automatic t_switch_fail();
    src_ready <= 8'hdf;
    pll_locked <= 1'b1;
    sw(3'h5);
    repeat (SET + 3) @(posedge hclk);
    chk(clk_sel, 32'h3);
    rd(CA, 32'h3521);
  endtask
  task automatic t_tune_sof();
    wr(TA, 32'h1005);
    rd(TA, 32'h1005);
    wr(TA, 32'h9005);
    wr(TA, 32'h902a);
    chk(rc_trim, 32'h05);
    wait_trim(6'h06);
    rd(TA, 32'h9a06);
    chk(selftune_irq_flag, 32'h1);
    wr(TA, 32'h9500);
    repeat (3) @(posedge hclk);
    chk(selftune_irq_flag, 32'h0);
    wr(TA, 32'h0500);
    repeat (3) @(posedge hclk);
    chk(selftune_irq_flag, 32'h0);
    rd(TA, 32'h0506);
  endtask
  task automatic t_tune_secondary_crystal_osc();
    wr(TA, 32'h8000);
    repeat (10000) @(posedge hclk);
    chk(rc_trim, 32'h0);
    rd(TA, 32'h8000);
    secondary_crystal_osc_enabled <= 1'b1;
    wait_trim(6'h01);
    rd(TA, 32'h8a01);
    chk(selftune_irq_flag, 32'h1);
  endtask
  initial begin
    repeat (60000) @(posedge hclk);
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_switch_ok();
    t_broken();
    t_switch_fail();
    t_tune_sof();
    t_tune_secondary_crystal_osc();
    give_verdict();
  end
endmodule
`default_nettype wire
